// File: cxs_pkg.sv
// Package for the CPU exception entry and return sequencer
package cxs_pkg;
  localparam int          PSW_W       = 16;
  localparam int          PSW_T_BIT   = 1;
  localparam int          PSW_S_BIT   = 9;
  localparam int          PSW_P_BIT   = 10;
  localparam int          PSW_I_BIT   = 11;
  localparam int          PSW_U_BIT   = 8;
  localparam logic [7:0]  VEC_NONVEC  = 8'h00;
  localparam logic [7:0]  VEC_NMI     = 8'h01;
  localparam logic [31:0] VEC_SCALE   = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [31:0] MOD_SB_OFS  = 32'h0000_0000;
  localparam logic [31:0] MOD_PB_OFS  = 32'h0000_0008;

  typedef enum logic [2:0] {
    CXS_BUS_READ,
    CXS_BUS_WRITE,
    CXS_BUS_INTA,
    CXS_BUS_EOI
  } cxs_bus_kind_t;

  typedef struct packed {
    logic          valid;
    cxs_bus_kind_t kind;
    logic [31:0]   addr;
    logic [31:0]   wdata;
  } cxs_bus_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } cxs_bus_rsp_t;

  typedef struct packed {
    logic [31:0]      pc;
    logic [PSW_W-1:0] psw;
    logic [15:0]      sel;
    logic [31:0]      sb;
    logic [31:0]      sp;
  } cxs_regs_t;

  // Decoded trap request from the execution unit
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } cxs_trap_t;

  typedef struct packed {
    logic       valid;
    logic       is_interrupt_return_op;
    logic [15:0] discard;
  } cxs_ret_t;
endpackage

// File: cxs_bus_port.sv
// Single-outstanding bus request holder for the sequencer
`timescale 1ns/1ps
module cxs_bus_port (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  start,
  input  wire cxs_pkg::cxs_bus_kind_t kind,
  input  wire logic [31:0]           addr,
  input  wire logic [31:0]           wdata,
  input  wire cxs_pkg::cxs_bus_rsp_t bus_rsp,
  output cxs_pkg::cxs_bus_req_t      bus_req,
  output logic                       done,
  output logic [31:0]                rdata
);
  import cxs_pkg::*;

  typedef struct packed {
    cxs_bus_req_t req;
    logic         done;
    logic [31:0]  rdata;
  } cxs_bp_state_t;

  cxs_bp_state_t st;
  cxs_bp_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.req.valid && bus_rsp.done) begin
      next_st.req.valid = 1'b0;
      next_st.done = 1'b1;
      next_st.rdata = bus_rsp.rdata;
    end else if (!st.req.valid && start) begin
      next_st.req.valid = 1'b1;
      next_st.req.kind = kind;
      next_st.req.addr = addr;
      next_st.req.wdata = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_req = st.req;
  assign done = st.done;
  assign rdata = st.rdata;
endmodule

// File: cxs_exception_seq.sv
// Exception entry and return sequencer
`timescale 1ns/1ps
module cxs_exception_seq (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  insn_boundary,
  input  wire logic                  dsp_event,
  input  wire logic                  nmi_n,
  input  wire logic                  maskable_irq_n,
  input  wire cxs_pkg::cxs_trap_t    trap_req,
  input  wire cxs_pkg::cxs_ret_t     ret_req,
  input  wire logic                  direct_dispatch_enable,
  input  wire logic                  vectored_mode,
  input  wire logic [31:0]           dispatch_table_base,
  input  wire cxs_pkg::cxs_regs_t    cpu_regs,
  input  wire cxs_pkg::cxs_bus_rsp_t bus_rsp,
  output cxs_pkg::cxs_bus_req_t      bus_req,
  output cxs_pkg::cxs_regs_t         new_regs,
  output logic                       regs_load,
  output logic                       busy,
  output logic                       eoi_pulse
);
  import cxs_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ACK, S_PUSH_PSW, S_PUSH_SEL, S_PUSH_PC, S_TABLE,
    S_SB, S_PB, S_DONE, S_POP_PC, S_POP_SEL, S_POP_PSW,
    S_RSB, S_EOI
  } cxs_state_t;

  typedef struct packed {
    cxs_state_t  state;
    logic        issued;
    logic        nmi_prev;
    logic        nmi_pend;
    logic        is_irq;
    logic        is_nmi;
    logic        de;
    logic        vec_mode;
    logic [7:0]  vector;
    logic [PSW_W-1:0] psw_copy;
    logic [31:0] desc;
    cxs_regs_t   regs;
    logic        load;
    logic        eoi;
    logic        ret_interrupt_return_op;
    logic [15:0] discard;
    logic        busy;
  } cxs_seq_state_t;

  cxs_seq_state_t st;
  cxs_seq_state_t next_st;
  logic           bp_start;
  cxs_bus_kind_t  bp_kind;
  logic [31:0]    bp_addr;
  logic [31:0]    bp_wdata;
  logic           bp_done;
  logic [31:0]    bp_rdata;
  logic           irq_ok;

  function automatic logic [31:0] push_addr(input logic [31:0] sp);
    return sp - WORD_BYTES;
  endfunction

  cxs_bus_port u_port (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (bp_start),
    .kind    (bp_kind),
    .addr    (bp_addr),
    .wdata   (bp_wdata),
    .bus_rsp (bus_rsp),
    .bus_req (bus_req),
    .done    (bp_done),
    .rdata   (bp_rdata)
  );

  // Gated by the live status word; a held low level keeps requesting
  assign irq_ok = (!maskable_irq_n || dsp_event)
                  && cpu_regs.psw[PSW_I_BIT];

  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    next_st.eoi = 1'b0;
    next_st.nmi_prev = nmi_n;
    bp_start = 1'b0;
    bp_kind = CXS_BUS_READ;
    bp_addr = '0;
    bp_wdata = '0;
    // Falling edge latched; a set beats the clear at entry
    if (st.nmi_prev && !nmi_n) next_st.nmi_pend = 1'b1;
    case (st.state)
      S_IDLE: begin
        next_st.issued = 1'b0;
        if (insn_boundary && (st.nmi_pend || irq_ok || trap_req.valid)) begin
          next_st.regs = cpu_regs;
          next_st.psw_copy = cpu_regs.psw;
          next_st.de = direct_dispatch_enable;
          next_st.vec_mode = vectored_mode;
          next_st.is_nmi = st.nmi_pend;
          next_st.is_irq = st.nmi_pend || irq_ok;
          if (st.nmi_pend && !(st.nmi_prev && !nmi_n)) next_st.nmi_pend = 1'b0;
          next_st.regs.psw[PSW_S_BIT] = 1'b1;
          next_st.regs.psw[PSW_U_BIT] = 1'b0;
          next_st.regs.psw[PSW_T_BIT] = 1'b0;
          next_st.regs.psw[PSW_P_BIT] = 1'b0;
          if (st.nmi_pend || irq_ok) begin
            next_st.regs.psw[PSW_I_BIT] = 1'b0;
            next_st.state = S_ACK;
          end else begin
            next_st.vector = trap_req.vector;
            next_st.state = S_PUSH_PSW;
          end
        end else if (ret_req.valid) begin
          next_st.regs = cpu_regs;
          next_st.ret_interrupt_return_op = ret_req.is_interrupt_return_op;
          next_st.discard = ret_req.is_interrupt_return_op ? 16'h0000 : ret_req.discard;
          next_st.de = direct_dispatch_enable;
          next_st.state = S_POP_PC;
        end
      end
      S_ACK: begin
        bp_start = !st.issued;
        bp_kind = CXS_BUS_INTA;
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          if (st.is_nmi) next_st.vector = VEC_NMI;
          else if (st.vec_mode) next_st.vector = bp_rdata[7:0];
          else next_st.vector = VEC_NONVEC;
          next_st.state = S_PUSH_PSW;
        end
      end
      S_PUSH_PSW, S_PUSH_SEL, S_PUSH_PC: begin
        bp_start = !st.issued;
        bp_kind = CXS_BUS_WRITE;
        bp_addr = push_addr(st.regs.sp);
        // Direct mode writes a reserved filler word
        bp_wdata = (st.state == S_PUSH_PSW) ? {16'h0000, st.psw_copy} :
                   (st.state == S_PUSH_SEL) ?
                   (st.de ? 32'h0000_0000 : {16'h0000, st.regs.sel}) :
                   st.regs.pc;
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          next_st.regs.sp = push_addr(st.regs.sp);
          next_st.state = (st.state == S_PUSH_PSW) ? S_PUSH_SEL :
                          (st.state == S_PUSH_SEL) ? S_PUSH_PC : S_TABLE;
        end
      end
      S_TABLE: begin
        bp_start = !st.issued;
        bp_addr = dispatch_table_base
                  + {24'h000000, st.vector} * VEC_SCALE;
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          next_st.desc = bp_rdata;
          if (st.de) begin
            next_st.regs.pc = bp_rdata;
            next_st.state = S_DONE;
          end else begin
            next_st.regs.sel = bp_rdata[15:0];
            next_st.state = S_SB;
          end
        end
      end
      S_SB, S_PB: begin
        bp_start = !st.issued;
        bp_addr = {16'h0000, st.regs.sel}
                  + ((st.state == S_SB) ? MOD_SB_OFS : MOD_PB_OFS);
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          if (st.state == S_SB) begin
            next_st.regs.sb = bp_rdata;
            next_st.state = S_PB;
          end else begin
            next_st.regs.pc = bp_rdata + {16'h0000, st.desc[31:16]};
            next_st.state = S_DONE;
          end
        end
      end
      S_DONE: begin
        next_st.load = 1'b1;
        next_st.state = S_IDLE;
      end
      S_POP_PC, S_POP_SEL, S_POP_PSW: begin
        bp_start = !st.issued;
        bp_addr = st.regs.sp;
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          next_st.regs.sp = st.regs.sp + WORD_BYTES;
          if (st.state == S_POP_PC) begin
            next_st.regs.pc = bp_rdata;
            next_st.state = S_POP_SEL;
          end else if (st.state == S_POP_SEL) begin
            if (!st.de) next_st.regs.sel = bp_rdata[15:0];
            next_st.state = S_POP_PSW;
          end else begin
            // Restores the saved I bit
            next_st.regs.psw = bp_rdata[PSW_W-1:0];
            next_st.regs.sp = st.regs.sp + WORD_BYTES
                              + {16'h0000, st.discard};
            next_st.state = st.de ? S_EOI : S_RSB;
          end
        end
      end
      S_RSB: begin
        bp_start = !st.issued;
        bp_addr = {16'h0000, st.regs.sel} + MOD_SB_OFS;
        next_st.issued = 1'b1;
        if (bp_done) begin
          next_st.issued = 1'b0;
          next_st.regs.sb = bp_rdata;
          next_st.state = S_EOI;
        end
      end
      S_EOI: begin
        if (!st.ret_interrupt_return_op) begin
          next_st.state = S_DONE;
        end else begin
          bp_start = !st.issued;
          bp_kind = CXS_BUS_EOI;
          next_st.issued = 1'b1;
          if (bp_done) begin
            next_st.issued = 1'b0;
            next_st.eoi = 1'b1;
            next_st.state = S_DONE;
          end
        end
      end
      default: next_st.state = S_IDLE;
    endcase
    next_st.busy = (next_st.state != S_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: S_IDLE, nmi_prev: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign new_regs = st.regs;
  assign regs_load = st.load;
  assign busy = st.busy;
  assign eoi_pulse = st.eoi;

  nmi_vector_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_ACK && bp_done && st.is_nmi) |=> st.vector == VEC_NMI)
    else $error("nmi vector not one");
  nonvec_zero_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_ACK && bp_done && !st.is_nmi && !st.vec_mode)
    |=> st.vector == VEC_NONVEC) else $error("nonvectored not zero");
  irq_clears_i_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_PUSH_PSW && st.is_irq) |-> !st.regs.psw[PSW_I_BIT])
    else $error("I bit set in interrupt entry");
  trace_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_PUSH_PSW) |-> !st.regs.psw[PSW_T_BIT]
    && st.regs.psw[PSW_S_BIT]) else $error("entry psw wrong");
  mode_held_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (busy && $past(busy)) |-> $stable(st.de) && $stable(st.vec_mode))
    else $error("mode bits changed");
  masked_ignored_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_IDLE && insn_boundary && !st.nmi_pend
     && !cpu_regs.psw[PSW_I_BIT] && !trap_req.valid && !ret_req.valid)
    |=> st.state == S_IDLE) else $error("masked irq taken");
  direct_pc_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_TABLE && bp_done && st.de)
    |=> st.regs.pc == $past(bp_rdata)) else $error("direct pc wrong");
  eoi_only_interrupt_return_op_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    eoi_pulse |-> st.ret_interrupt_return_op) else $error("eoi without interrupt_return_op");
  nmi_first_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_IDLE && insn_boundary && st.nmi_pend)
    |=> st.state == S_ACK && st.is_nmi) else $error("nmi not first");
  level_retrig_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_IDLE && insn_boundary && !maskable_irq_n
     && cpu_regs.psw[PSW_I_BIT]) |=> st.state == S_ACK)
    else $error("held request not taken");
  table_addr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_TABLE && bus_req.valid)
    |-> bus_req.addr == dispatch_table_base + {22'h0, st.vector, 2'h0})
    else $error("table address wrong");
  vec_from_bus_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_ACK && bp_done && !st.is_nmi && st.vec_mode)
    |=> st.vector == $past(bp_rdata[7:0])) else $error("vector not taken");
  desc_pc_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_PB && bp_done)
    |=> st.regs.pc == $past(bp_rdata) + {16'h0000, st.desc[31:16]})
    else $error("descriptor pc wrong");
  interrupt_return_op_keep_sp_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_POP_PSW && bp_done && st.ret_interrupt_return_op)
    |=> st.regs.sp == $past(st.regs.sp) + WORD_BYTES)
    else $error("interrupt_return_op discarded bytes");
  trap_keeps_i_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_PUSH_PSW && !st.is_irq)
    |-> st.regs.psw[PSW_I_BIT] == st.psw_copy[PSW_I_BIT])
    else $error("trap changed I bit");
  direct_sel_kept_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.state == S_TABLE && bp_done && st.de)
    |=> st.regs.sel == $past(st.regs.sel)) else $error("selector changed");
endmodule

// File: cxs_vec_ctrl_model.sv
// Memory and vector controller model behind the sequencer bus port
`timescale 1ns/1ps
module cxs_vec_ctrl_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  slow,
  input  wire logic [7:0]            vector,
  input  wire cxs_pkg::cxs_bus_req_t bus_req,
  output cxs_pkg::cxs_bus_rsp_t      bus_rsp
);
  import cxs_pkg::*;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wq_addr [$];
  logic [31:0] wq_data [$];
  int          inta_cnt;
  int          eoi_cnt;
  int          hold;
  logic [31:0] d;
  // Idle data keeps moving so a stale read never looks valid
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rsp <= '0;
      hold = 0;
    end else if (bus_rsp.done) begin
      bus_rsp.done <= 1'b0;
      bus_rsp.rdata <= ~bus_rsp.rdata;
    end else if (bus_req.valid === 1'b1) begin
      if (slow && hold < 3) begin
        hold = hold + 1;
      end else begin
        hold = 0;
        d = mem.exists(bus_req.addr) ? mem[bus_req.addr] : ~bus_req.addr;
        case (bus_req.kind)
          CXS_BUS_WRITE: begin
            mem[bus_req.addr] = bus_req.wdata;
            wq_addr.push_back(bus_req.addr);
            wq_data.push_back(bus_req.wdata);
          end
          CXS_BUS_INTA: begin
            inta_cnt++;
            // Upper bytes are junk: only the low byte carries the vector
            d = {24'hc3a55a, vector};
          end
          CXS_BUS_EOI: eoi_cnt++;
          default: ;
        endcase
        bus_rsp <= '{1'b1, d};
      end
    end else begin
      bus_rsp.rdata <= bus_rsp.rdata + 32'h1357_9bdf;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
module testbench;
  import cxs_pkg::*;
  logic         sys_clk;
  logic         rst_n;
  logic         insn_boundary;
  logic         dsp_event;
  logic         nmi_n;
  logic         maskable_irq_n;
  logic         direct_dispatch_enable;
  logic         vectored_mode;
  logic         slow;
  logic [7:0]   vec;
  cxs_trap_t    trap_req;
  cxs_ret_t     ret_req;
  cxs_regs_t    cpu_regs;
  cxs_regs_t    r;
  cxs_bus_req_t bus_req;
  cxs_bus_rsp_t bus_rsp;
  cxs_regs_t    new_regs;
  logic         regs_load;
  logic         busy;
  logic         eoi_pulse;
  int           num_errors;
  int           n_compared;
  int           n_eoi;
  int           n;
  logic [31:0]  sp_a;

  cxs_exception_seq dut (
    .sys_clk, .rst_n, .insn_boundary, .dsp_event, .nmi_n,
    .maskable_irq_n, .trap_req, .ret_req, .direct_dispatch_enable,
    .vectored_mode, .dispatch_table_base(32'h0000_2000), .cpu_regs,
    .bus_rsp, .bus_req, .new_regs, .regs_load, .busy, .eoi_pulse
  );
  cxs_vec_ctrl_model mdl (
    .sys_clk, .rst_n, .slow, .vector(vec), .bus_req, .bus_rsp
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (eoi_pulse === 1'b1) n_eoi++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_load;
    int i;
    i = 0;
    while (regs_load !== 1'b1 && i < 400) begin
      @(negedge sys_clk);
      i++;
    end
    chk("regs_load", {31'h0, regs_load}, 32'h1);
    r = new_regs;
    @(negedge sys_clk);
  endtask
  // Retriggers from held levels are let run out before the next case
  task automatic idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      @(negedge sys_clk);
      i++;
    end
    repeat (4) @(negedge sys_clk);
    mdl.wq_data.delete();
    mdl.wq_addr.delete();
  endtask
  task automatic chk_push(input logic mid);
    chk("push count", 32'(mdl.wq_data.size()), 32'h3);
    chk("push psw", {16'h0, mdl.wq_data[0][15:0]}, 32'h0000_0b02);
    if (mid) chk("push sel", {16'h0, mdl.wq_data[1][15:0]}, 32'h0300);
    chk("push pc", mdl.wq_data[2], 32'h0000_1000);
    chk("push step", mdl.wq_addr[0] - mdl.wq_addr[2], 32'h8);
  endtask
  task automatic s_irq_desc;
    mdl.mem[32'h2014] = 32'h0100_0400;
    mdl.mem[32'h0400] = 32'h0000_9000;
    mdl.mem[32'h0408] = 32'h0000_a000;
    vec = 8'h05;
    @(posedge sys_clk);
    maskable_irq_n <= 1'b0;
    wait_load;
    chk("pc", r.pc, 32'h0000_a100);
    chk("sel", {16'h0, r.sel}, 32'h0000_0400);
    chk("sb", r.sb, 32'h0000_9000);
    chk("psw", {16'h0, r.psw & 16'h0b02}, 32'h0000_0200);
    chk_push(1'b1);
    wait_load;
    @(posedge sys_clk);
    maskable_irq_n <= 1'b1;
    idle;
  endtask
  task automatic s_direct;
    mdl.mem[32'h2000] = 32'h0000_5550;
    vec = 8'h07;
    slow = 1'b1;
    n = mdl.inta_cnt;
    @(posedge sys_clk);
    direct_dispatch_enable <= 1'b1;
    vectored_mode <= 1'b0;
    maskable_irq_n <= 1'b0;
    wait_load;
    chk("pc", r.pc, 32'h0000_5550);
    chk("inta", 32'(mdl.inta_cnt - n), 32'h1);
    chk_push(1'b0);
    @(posedge sys_clk);
    maskable_irq_n <= 1'b1;
    vectored_mode <= 1'b1;
    idle;
    slow = 1'b0;
  endtask
  task automatic s_nmi;
    mdl.mem[32'h2004] = 32'h0000_6660;
    vec = 8'h05;
    @(posedge sys_clk);
    insn_boundary <= 1'b0;
    maskable_irq_n <= 1'b0;
    nmi_n <= 1'b0;
    @(posedge sys_clk);
    insn_boundary <= 1'b1;
    wait_load;
    chk("pc", r.pc, 32'h0000_6660);
    chk("psw i", {31'h0, r.psw[PSW_I_BIT]}, 32'h0);
    @(posedge sys_clk);
    maskable_irq_n <= 1'b1;
    nmi_n <= 1'b1;
    idle;
  endtask
  task automatic s_dsp;
    mdl.mem[32'h2018] = 32'h0000_8880;
    vec = 8'h06;
    @(posedge sys_clk);
    dsp_event <= 1'b1;
    wait_load;
    chk("dsp pc", r.pc, 32'h0000_8880);
    @(posedge sys_clk);
    dsp_event <= 1'b0;
    idle;
  endtask
  task automatic s_trap_masked;
    mdl.mem[32'h200c] = 32'h0000_7770;
    n = 0;
    @(posedge sys_clk);
    cpu_regs.psw <= 16'h0302;
    maskable_irq_n <= 1'b0;
    repeat (30) begin
      @(negedge sys_clk);
      if (busy !== 1'b0) n++;
    end
    chk("masked busy", 32'(n), 32'h0);
    n = mdl.inta_cnt;
    @(posedge sys_clk);
    maskable_irq_n <= 1'b1;
    cpu_regs.psw <= 16'h0b02;
    trap_req <= '{1'b1, 8'h03};
    wait_load;
    @(posedge sys_clk);
    trap_req.valid <= 1'b0;
    chk("pc", r.pc, 32'h0000_7770);
    chk("psw", {16'h0, r.psw & 16'h0b02}, 32'h0a00);
    chk("inta", 32'(mdl.inta_cnt - n), 32'h0);
    idle;
  endtask
  task automatic go_ret(input logic interrupt_return_op, input logic [15:0] disc);
    int i;
    i = 0;
    @(posedge sys_clk);
    ret_req <= '{1'b1, interrupt_return_op, disc};
    while (busy !== 1'b1 && i < 50) begin
      @(negedge sys_clk);
      i++;
    end
    @(posedge sys_clk);
    ret_req.valid <= 1'b0;
    wait_load;
    chk("ret pc", r.pc, 32'h0000_1234);
    chk("ret psw", {16'h0, r.psw}, 32'h0000_0b02);
  endtask
  task automatic s_returns;
    mdl.mem[32'h8000] = 32'h0000_1234;
    mdl.mem[32'h8004] = 32'h0000_0500;
    mdl.mem[32'h8008] = 32'h0000_0b02;
    mdl.mem[32'h0500] = 32'h0000_4321;
    n = mdl.eoi_cnt;
    n_eoi = 0;
    @(posedge sys_clk);
    direct_dispatch_enable <= 1'b0;
    cpu_regs.psw <= 16'h0302;
    go_ret(1'b1, 16'h0020);
    chk("ret sel", {16'h0, r.sel}, 32'h0000_0500);
    chk("ret sb", r.sb, 32'h0000_4321);
    chk("eoi cycles", 32'(mdl.eoi_cnt - n), 32'h1);
    chk("eoi pulses", 32'(n_eoi), 32'h1);
    chk("interrupt_return_op sp", r.sp, 32'h0000_800c);
    sp_a = r.sp;
    go_ret(1'b0, 16'h0010);
    chk("eoi after trap ret", 32'(n_eoi), 32'h1);
    chk("discard", r.sp - sp_a, 32'h0000_0010);
  endtask

  initial begin
    rst_n = 1'b0;
    insn_boundary = 1'b1;
    dsp_event = 1'b0;
    nmi_n = 1'b1;
    maskable_irq_n = 1'b1;
    direct_dispatch_enable = 1'b0;
    vectored_mode = 1'b1;
    slow = 1'b0;
    vec = 8'h00;
    trap_req = '0;
    ret_req = '0;
    cpu_regs = '{32'h0000_1000, 16'h0b02, 16'h0300, 32'h0000_7000,
                 32'h0000_8000};
    num_errors = 0;
    n_compared = 0;
    n_eoi = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_irq_desc;
    s_direct;
    s_nmi;
    s_dsp;
    s_trap_masked;
    s_returns;
    results;
  end
  // About seventy times the expected run
  initial begin
    #300000;
    num_errors++;
    results;
  end
endmodule
